//--- core/timing_pattern_output.sv
// timing pattern output unit: register file, port data and direction,
// four output groups fed by timer compare matches.
// assumes a byte register port with read data one cycle after the strobe,
// and compare matches arriving as one-cycle pulses on core_clk.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R01 - sixteen pulse output bits, each enabled for pattern output on its own
// R02 - four 4-bit groups run at the same time, independently
// R03 - each group's trigger is one of three timer compare matches
// R04 - non-overlap mode puts a margin between successive output changes
// R05 - selected compare matches also raise dma start requests
// R06 - pins 0-3 group 0, 4-7 group 1, 8-11 group 2, 12-15 group 3
// R07 - reset: mode F0, control FF, all other registers 00
// R08 - port data bits under pattern output ignore writes, stay readable
// R09 - port A next data: shared trigger at A5, split puts group 0 at A7
// R10 - port B next data: shared trigger at A4, split puts group 2 at A6
// R11 - software sets direction bits of pattern pins to output
// R12 - port A direction is write-only, one bit per pin
// R13 - addresses decoded on the low twenty bits
// R14 - on its trigger a group copies next data into port data
// R15 - unused next-data halves ignore writes and read as ones
// R16 - next data cleared by reset and hardware standby only
// R17 - a transfer updates only bits whose next-data enable is set
module timing_pattern_output
   import pattern_pkg::*;
#(
   parameter int NOV_CYC = pattern_pkg::NOV_MARGIN_CYC
)(
   input  wire logic                             core_clk,
   input  wire logic                             nrst,
   input  wire logic                             hwStandby,
   input  wire logic [pattern_pkg::ADDR_W-1:0]   regAddr,
   input  wire logic [7:0]                       wrData,
   input  wire logic                             wrStb,
   input  wire logic                             rdStb,
   output logic      [7:0]                       rdData,
   input  wire logic [pattern_pkg::TIMER_CH-1:0] cmpMatch,
   input  wire logic [15:0]                      pinIn,
   output logic      [15:0]                      patternOut,
   output logic      [15:0]                      patternOe,
   output logic      [pattern_pkg::TIMER_CH-1:0] dmaStart
);
   import pattern_pkg::*;

   logic [7:0]          mode_q;
   logic [7:0]          ctrl_q;
   logic [15:0]         nde_q;
   logic [15:0]         ndr_q, ndr_d;
   logic [15:0]         port_q, port_d;
   logic [15:0]         dir_q;
   logic [7:0]          rdData_d;
   logic [15:0]         loadMask, loadVal;
   logic [GROUPS-1:0]   groupTrig;
   logic [TIMER_CH-1:0] dmaReq;

   // address decode
   wire logic [DEC_W-1:0] a = regAddr[DEC_W-1:0];  // R13
   wire logic hitDirA  = (a == OFF_DIR_A);
   wire logic hitDirB  = (a == OFF_DIR_B);
   wire logic hitMode  = (a == OFF_MODE);
   wire logic hitCtrl  = (a == OFF_CTRL);
   wire logic hitNdeB  = (a == OFF_NDE_B);
   wire logic hitNdeA  = (a == OFF_NDE_A);
   wire logic hitNdrBH = (a == OFF_NDR_B_HI);
   wire logic hitNdrAH = (a == OFF_NDR_A_HI);
   wire logic hitNdrBL = (a == OFF_NDR_B_LO);
   wire logic hitNdrAL = (a == OFF_NDR_A_LO);
   wire logic hitPortA = (a == OFF_PORT_A);
   wire logic hitPortB = (a == OFF_PORT_B);

   // shared trigger within each port half
   wire logic sameA = (trigSel(ctrl_q, 0) == trigSel(ctrl_q, 1));
   wire logic sameB = (trigSel(ctrl_q, 2) == trigSel(ctrl_q, 3));

   // next-data write lanes, one per group nibble
   wire logic wrA1 = wrStb && hitNdrAH;                          // R09
   wire logic wrA0 = wrStb && (sameA ? hitNdrAH : hitNdrAL);     // R09
   wire logic wrB3 = wrStb && hitNdrBH;                          // R10
   wire logic wrB2 = wrStb && (sameB ? hitNdrBH : hitNdrBL);     // R10
   wire logic [15:0] ndrWrMask = {{4{wrB3}}, {4{wrB2}}, {4{wrA1}}, {4{wrA0}}};

   always_comb begin
      ndr_d = (ndr_q & ~ndrWrMask) | ({wrData, wrData} & ndrWrMask);
      if (hwStandby) begin
         ndr_d = '0;  // R16
      end
   end

   // port data: cpu writes only where pattern output is off
   wire logic [15:0] portSel    = {{8{hitPortB}}, {8{hitPortA}}};
   wire logic [15:0] portWrMask = (wrStb ? portSel : 16'h0000) & ~nde_q;  // R08
   always_comb begin
      port_d = (port_q & ~(portWrMask | loadMask))
             | ({wrData, wrData} & portWrMask)
             | (loadVal & loadMask);  // R14 R17
   end

   // read path: reserved halves and unreadable registers read as ones
   wire logic [15:0] portRd = (port_q & dir_q) | (pinIn & ~dir_q);
   wire logic [7:0]  ndrAH  = sameA ? ndr_q[7:0]   : {ndr_q[7:4], NIB_ONES};    // R15
   wire logic [7:0]  ndrAL  = sameA ? READ_ONES    : {NIB_ONES, ndr_q[3:0]};    // R15
   wire logic [7:0]  ndrBH  = sameB ? ndr_q[15:8]  : {ndr_q[15:12], NIB_ONES};  // R15
   wire logic [7:0]  ndrBL  = sameB ? READ_ONES    : {NIB_ONES, ndr_q[11:8]};   // R15
   assign rdData_d = !rdStb  ? RST_ZERO :
                     hitMode  ? mode_q :
                     hitCtrl  ? ctrl_q :
                     hitNdeA  ? nde_q[7:0] :
                     hitNdeB  ? nde_q[15:8] :
                     hitNdrAH ? ndrAH :
                     hitNdrAL ? ndrAL :
                     hitNdrBH ? ndrBH :
                     hitNdrBL ? ndrBL :
                     hitPortA ? portRd[7:0] :
                     hitPortB ? portRd[15:8] :
                     READ_ONES;  // direction registers are write-only (R12)

   // trigger selection and dma requests
   trigger_select uSel (
      .ctrl      (ctrl_q),
      .cmpMatch  (cmpMatch),
      .groupTrig (groupTrig),
      .dmaReq    (dmaReq)
   );

   // four independent groups, group g on bits 4g+3:4g
   group_if grp [GROUPS] ();
   genvar g;
   generate
      for (g = 0; g < GROUPS; g++) begin : gGrp  // R02 R06
         assign grp[g].trig = groupTrig[g];
         assign grp[g].nov  = mode_q[MODE_NOV_LSB + g];
         assign grp[g].nde  = nde_q[4*g +: 4];  // R01
         assign grp[g].ndr  = ndr_q[4*g +: 4];
         assign grp[g].cur  = port_q[4*g +: 4];
         assign loadMask[4*g +: 4] = grp[g].loadMask;
         assign loadVal[4*g +: 4]  = grp[g].loadVal;
         pattern_group #(
            .NOV_CYC (NOV_CYC)
         ) uGrp (
            .core_clk (core_clk),
            .nrst     (nrst),
            .bus      (grp[g].grp)
         );
      end
   endgenerate

   // control registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= RST_MODE;  // R07
         ctrl_q <= RST_CTRL;
         nde_q  <= {RST_ZERO, RST_ZERO};
         dir_q  <= {RST_ZERO, RST_ZERO};
      end else if (wrStb) begin
         if (hitMode) mode_q <= {MODE_FIXED, wrData[3:0]};
         if (hitCtrl) ctrl_q <= wrData;
         if (hitNdeA) nde_q[7:0] <= wrData;
         if (hitNdeB) nde_q[15:8] <= wrData;
         if (hitDirA) dir_q[7:0] <= wrData;  // R12
         if (hitDirB) dir_q[15:8] <= wrData;
      end
   end

   // data registers and outputs
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ndr_q    <= {RST_ZERO, RST_ZERO};  // R07 R16
         port_q   <= {RST_ZERO, RST_ZERO};
         rdData   <= RST_ZERO;
         dmaStart <= '0;
      end else begin
         ndr_q    <= ndr_d;
         port_q   <= port_d;
         rdData   <= rdData_d;
         dmaStart <= dmaReq;  // R05
      end
   end

   assign patternOut = port_q;
   assign patternOe  = dir_q;  // R11
endmodule : timing_pattern_output
`default_nettype wire

//--- inc/pattern_pkg.sv
// constants shared by the timing pattern output unit: register offsets,
// field positions, reset values and the non-overlap margin.
// assumes a byte-wide register port decoded on the low 20 address bits.
package pattern_pkg;
   localparam int          ADDR_W        = 24;
   localparam int          DEC_W         = 20;
   localparam int          GROUPS        = 4;
   localparam int          TIMER_CH      = 3;

   localparam logic [19:0] OFF_DIR_A     = 20'hEE009;
   localparam logic [19:0] OFF_DIR_B     = 20'hEE00A;
   localparam logic [19:0] OFF_MODE      = 20'hFFFA0;
   localparam logic [19:0] OFF_CTRL      = 20'hFFFA1;
   localparam logic [19:0] OFF_NDE_B     = 20'hFFFA2;
   localparam logic [19:0] OFF_NDE_A     = 20'hFFFA3;
   localparam logic [19:0] OFF_NDR_B_HI  = 20'hFFFA4;
   localparam logic [19:0] OFF_NDR_A_HI  = 20'hFFFA5;
   localparam logic [19:0] OFF_NDR_B_LO  = 20'hFFFA6;
   localparam logic [19:0] OFF_NDR_A_LO  = 20'hFFFA7;
   localparam logic [19:0] OFF_PORT_A    = 20'hFFFD9;
   localparam logic [19:0] OFF_PORT_B    = 20'hFFFDA;

   localparam logic [7:0]  RST_MODE      = 8'hF0;
   localparam logic [7:0]  RST_CTRL      = 8'hFF;
   localparam logic [7:0]  RST_ZERO      = 8'h00;
   localparam logic [7:0]  READ_ONES     = 8'hFF;
   localparam logic [3:0]  NIB_ONES      = 4'hF;

   // mode: bit g = non-overlap for group g, bits 7:4 fixed ones
   localparam int          MODE_NOV_LSB  = 0;
   localparam logic [3:0]  MODE_FIXED    = 4'hF;
   // control: two trigger-select bits per group, group g at bits 2g+1:2g
   localparam int          CTRL_SEL_W    = 2;

   localparam int          NOV_MARGIN_NS = 80;
   localparam int          CLK_PERIOD_NS = 8;
   localparam int          NOV_MARGIN_CYC = (NOV_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          NOV_CNT_W     = 8;

   typedef enum logic [0:0] {
      GRP_IDLE = 1'b0,
      GRP_WAIT = 1'b1
   } grp_state_t;

   // trigger channel selected for group g
   function automatic logic [1:0] trigSel(input logic [7:0] ctrl, input int g);
      trigSel = ctrl[g*CTRL_SEL_W +: CTRL_SEL_W];
   endfunction : trigSel
endpackage : pattern_pkg

//--- inc/group_if.sv
// signals between the register core and one 4-bit output group.
// assumes one instance per group, all on core_clk.
`timescale 1ns/1ps
`default_nettype none
interface group_if;
   logic       trig;
   logic       nov;
   logic [3:0] nde;
   logic [3:0] ndr;
   logic [3:0] cur;
   logic [3:0] loadMask;
   logic [3:0] loadVal;
   modport ctrl (output trig, nov, nde, ndr, cur, input loadMask, loadVal);
   modport grp  (input trig, nov, nde, ndr, cur, output loadMask, loadVal);
endinterface : group_if
`default_nettype wire

//--- core/trigger_select.sv
// picks each group's trigger from the timer compare matches and flags the
// matches that some group uses as dma start requests.
// assumes compare matches are one-cycle pulses on core_clk.
`timescale 1ns/1ps
`default_nettype none
module trigger_select
   import pattern_pkg::*;
(
   input  wire logic [7:0]          ctrl,
   input  wire logic [TIMER_CH-1:0] cmpMatch,
   output logic      [GROUPS-1:0]   groupTrig,
   output logic      [TIMER_CH-1:0] dmaReq
);
   logic [TIMER_CH-1:0] used [GROUPS];

   genvar g;
   generate
      for (g = 0; g < GROUPS; g++) begin : gSel
         wire logic [1:0] s = trigSel(ctrl, g);
         // code 3 is taken as channel 2
         wire logic [1:0] ch = (s == 2'h3) ? 2'h2 : s;
         assign groupTrig[g] = cmpMatch[ch];  // R03
         assign used[g] = 3'(3'h1 << ch);
      end
   endgenerate

   // R05
   assign dmaReq = cmpMatch & (used[0] | used[1] | used[2] | used[3]);
endmodule : trigger_select
`default_nettype wire

//--- core/pattern_group.sv
// one 4-bit output group: turns a trigger into port-data load masks,
// delaying rising bits by a margin when non-overlap is on.
// assumes the register core applies loadMask/loadVal on the same edge.
`timescale 1ns/1ps
`default_nettype none
module pattern_group
   import pattern_pkg::*;
#(
   parameter int NOV_CYC = NOV_MARGIN_CYC
)(
   input  wire logic core_clk,
   input  wire logic nrst,
   group_if.grp      bus
);
   grp_state_t           state_q, state_d;
   logic [NOV_CNT_W-1:0] cnt_q, cnt_d;
   logic [3:0]           rise_q, rise_d;

   wire logic       cntDone = (cnt_q == NOV_CNT_W'(1));
   wire logic       waiting = (state_q == GRP_WAIT);
   // pending rises are flushed at the margin end or when a new trigger comes
   wire logic [3:0] pendM   = (waiting && (cntDone || bus.trig)) ? rise_q : 4'h0;
   wire logic [3:0] curEff  = bus.cur | pendM;
   // non-overlap: falling bits now, rising bits after the margin
   wire logic [3:0] newM    = !bus.trig ? 4'h0 :
                              bus.nov ? (bus.nde & curEff & ~bus.ndr) : bus.nde;  // R04 R17
   wire logic [3:0] riseNew = bus.nde & ~curEff & bus.ndr;

   assign bus.loadMask = pendM | newM;  // R14
   assign bus.loadVal  = (bus.ndr & newM) | (pendM & ~newM);

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      rise_d  = rise_q;
      case (state_q)
         GRP_IDLE: begin
            if (bus.trig && bus.nov && (riseNew != 4'h0)) begin
               state_d = GRP_WAIT;
               cnt_d   = NOV_CNT_W'(NOV_CYC);
               rise_d  = riseNew;
            end
         end
         GRP_WAIT: begin
            cnt_d = cnt_q - NOV_CNT_W'(1);
            if (bus.trig && bus.nov && (riseNew != 4'h0)) begin
               cnt_d  = NOV_CNT_W'(NOV_CYC);
               rise_d = riseNew;
            end else if (bus.trig || cntDone) begin
               state_d = GRP_IDLE;
               rise_d  = 4'h0;
            end
         end
         default: begin
            state_d = GRP_IDLE;
            rise_d  = 4'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= GRP_IDLE;
         cnt_q   <= '0;
         rise_q  <= 4'h0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         rise_q  <= rise_d;
      end
   end
endmodule : pattern_group
`default_nettype wire

//--- bench/pattern_sva.sv
// port-level checks for the timing pattern output unit.
// assumes the byte register port and one-cycle compare match pulses.
`timescale 1ns/1ps
`default_nettype none
module pattern_sva
   import pattern_pkg::*;
#(
   parameter int NOV_CYC = 2
)(
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        hwStandby,
   input wire logic [23:0] regAddr,
   input wire logic [7:0]  wrData,
   input wire logic        wrStb,
   input wire logic        rdStb,
   input wire logic [7:0]  rdData,
   input wire logic [2:0]  cmpMatch,
   input wire logic [15:0] pinIn,
   input wire logic [15:0] patternOut,
   input wire logic [15:0] patternOe,
   input wire logic [2:0]  dmaStart
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   wire logic [19:0] dec = regAddr[19:0];
   sequence dirWrA_s; wrStb && dec == OFF_DIR_A; endsequence
   sequence dirWrB_s; wrStb && dec == OFF_DIR_B; endsequence
   sequence portRdA_s; rdStb && dec == OFF_PORT_A; endsequence

   rdIdle_a: assert property (!$past(rdStb) |-> rdData == 8'h00)
      else $error("read data not idle");
   dmaCause_a: assert property ((dmaStart & ~$past(cmpMatch)) == 3'h0)
      else $error("dma start without compare match");
   dirWrA_a: assert property (dirWrA_s |=> patternOe[7:0] == $past(wrData))
      else $error("port A direction not written");
   dirWrB_a: assert property (dirWrB_s |=> patternOe[15:8] == $past(wrData))
      else $error("port B direction not written");
   dirHold_a: assert property (!(wrStb && (dec == OFF_DIR_A || dec == OFF_DIR_B)) |=> $stable(patternOe))
      else $error("direction changed without write");
   modeFixed_a: assert property (rdStb && dec == OFF_MODE |=> rdData[7:4] == 4'hF)
      else $error("mode upper bits not ones");
   dirRead_a: assert property (rdStb && dec == OFF_DIR_A |=> rdData == 8'hFF)
      else $error("write-only register read back");
   portRead_a: assert property (portRdA_s |=> rdData == (($past(patternOut[7:0]) & $past(patternOe[7:0]))
      | ($past(pinIn[7:0]) & ~$past(patternOe[7:0]))))
      else $error("port A read mismatch");
   resetOut_a: assert property ($rose(nrst) |-> patternOut == 16'h0000 && patternOe == 16'h0000)
      else $error("outputs not cleared by reset");
endmodule : pattern_sva
`default_nettype wire

//--- bench/pin_load.sv
// external circuit on the pattern pins: follows driven pins, shows its own
// level on pins left as inputs so a stale value is never read back.
`timescale 1ns/1ps
`default_nettype none
module pin_load #(
   parameter logic [15:0] IDLE = 16'hA5C3
)(
   input  wire logic [15:0] patternOut,
   input  wire logic [15:0] patternOe,
   output logic      [15:0] pinIn
);
   assign pinIn = (patternOut & patternOe) | (IDLE & ~patternOe);
endmodule : pin_load
`default_nettype wire

//--- bench/timing_pattern_output_tb_top.sv
// self-checking bench for the timing pattern output unit.
// assumes NOV_CYC of 2 and the pin_load model on the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin nErrors++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module timing_pattern_output_tb_top;
   import pattern_pkg::*;
   localparam int NOV = 2;
   localparam logic [15:0] IDLE = 16'hA5C3;
   logic core_clk = 0, nrst = 0, hwStandby = 0, wrStb = 0, rdStb = 0;
   logic [23:0] regAddr = 24'h000000;
   logic [7:0]  wrData = 8'h00, rdData;
   logic [2:0]  cmpMatch = 3'h0, dmaStart;
   logic [15:0] pinIn, patternOut, patternOe;
   int nErrors = 0, comparisons = 0, cycles = 0;

   timing_pattern_output #(.NOV_CYC(NOV)) uut (.core_clk(core_clk), .nrst(nrst), .hwStandby(hwStandby),
      .regAddr(regAddr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .cmpMatch(cmpMatch),
      .pinIn(pinIn), .patternOut(patternOut), .patternOe(patternOe), .dmaStart(dmaStart));
   pin_load #(.IDLE(IDLE)) load (.patternOut(patternOut), .patternOe(patternOe), .pinIn(pinIn));

   initial begin
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         nErrors++;
         completeRun();
      end
   end

   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      @(posedge core_clk) begin regAddr <= a; wrData <= d; wrStb <= 1'b1; end
      @(posedge core_clk) wrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [23:0] a, output logic [7:0] d);
      @(posedge core_clk) begin regAddr <= a; rdStb <= 1'b1; end
      @(posedge core_clk) rdStb <= 1'b0;
      #1 d = rdData;
   endtask : rd
   task automatic trig(input int ch);
      @(posedge core_clk) cmpMatch <= 3'(1 << ch);
      @(posedge core_clk) cmpMatch <= 3'h0;
      #1;
   endtask : trig

   task automatic testReset;
      logic [7:0] d;
      `CHK(patternOut, 16'h0000)
      `CHK(patternOe, 16'h0000)
      rd(24'hFFFA0, d); `CHK(d, 8'hF0)
      rd(24'hFFFA1, d); `CHK(d, 8'hFF)
      rd(24'hFFFA2, d); `CHK(d, 8'h00)
      rd(24'hFFFA3, d); `CHK(d, 8'h00)
      rd(24'hFFFA4, d); `CHK(d, 8'h00)
      rd(24'hFFFA5, d); `CHK(d, 8'h00)
      rd(24'hFFFD9, d); `CHK(d, IDLE[7:0])
      rd(24'hFFFDA, d); `CHK(d, IDLE[15:8])
      rd(24'h000123, d); `CHK(d, 8'hFF)
      $display("reset values done");
   endtask : testReset

   task automatic testRegs;
      logic [7:0] d;
      wr(24'hEE009, 8'hFF);
      wr(24'hEE00A, 8'hFF);
      #1 `CHK(patternOe, 16'hFFFF)
      rd(24'hEE009, d); `CHK(d, 8'hFF)
      wr(24'hFFFA1, 8'h90);
      wr(24'hFFFA3, 8'hFF);
      wr(24'hFFFA2, 8'h0F);
      wr(24'hFFFD9, 8'h55);
      wr(24'hFFFDA, 8'hFF);
      #1 `CHK(patternOut, 16'hF000)
      rd(24'hFFFD9, d); `CHK(d, 8'h00)
      wr(24'hFFFA5, 8'h3C);
      wr(24'hFFFA6, 8'h05);
      wr(24'hFFFA4, 8'hA0);
      rd(24'hFFFA6, d); `CHK(d, 8'hF5)
      rd(24'hFFFA4, d); `CHK(d, 8'hAF)
      rd(24'hFFFA7, d); `CHK(d, 8'hFF)
      $display("register map done");
   endtask : testRegs

   task automatic testTrig;
      trig(0); `CHK(patternOut, 16'hF03C)
      `CHK(dmaStart, 3'h1)
      trig(1); `CHK(patternOut, 16'hF53C)
      `CHK(dmaStart, 3'h2)
      trig(2); `CHK(patternOut, 16'hF53C)
      `CHK(dmaStart, 3'h4)
      $display("trigger transfer done");
   endtask : testTrig

   task automatic testNov;
      logic [7:0] d;
      wr(24'hAFFFA0, 8'h01);
      rd(24'h0FFFA0, d); `CHK(d, 8'hF1)
      wr(24'hFFFA5, 8'hC3);
      trig(0); `CHK(patternOut, 16'hF5C0)
      repeat (NOV) @(posedge core_clk);
      #1 `CHK(patternOut, 16'hF5C3)
      $display("non-overlap done");
   endtask : testNov

   task automatic testStandby;
      logic [7:0] d;
      @(posedge core_clk) hwStandby <= 1'b1;
      @(posedge core_clk) hwStandby <= 1'b0;
      rd(24'hFFFA5, d); `CHK(d, 8'h00)
      rd(24'hFFFA6, d); `CHK(d, 8'hF0)
      `CHK(patternOut, 16'hF5C3)
      $display("standby done");
   endtask : testStandby

   // select code 3 means channel 2; a channel no group selects raises no dma start
   task automatic testSel3;
      wr(24'hFFFA0, 8'h00);
      wr(24'hFFFA1, 8'hFF);
      wr(24'hFFFA5, 8'h5A);
      trig(2); `CHK(patternOut, 16'hF05A)
      `CHK(dmaStart, 3'h4)
      trig(1); `CHK(patternOut, 16'hF05A)
      `CHK(dmaStart, 3'h0)
      $display("code three select done");
   endtask : testSel3

   task automatic completeRun;
      $display("comparisons %0d mismatches %0d", comparisons, nErrors);
      if (nErrors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : completeRun

   initial begin
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      #1 testReset();
      testRegs();
      testTrig();
      testNov();
      testStandby();
      testSel3();
      completeRun();
   end
endmodule : timing_pattern_output_tb_top
bind timing_pattern_output pattern_sva #(.NOV_CYC(NOV_CYC)) chk (.core_clk(core_clk), .nrst(nrst),
   .hwStandby(hwStandby), .regAddr(regAddr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
   .cmpMatch(cmpMatch), .pinIn(pinIn), .patternOut(patternOut), .patternOe(patternOe), .dmaStart(dmaStart));
`default_nettype wire
